// ===== logic/pcit_core.sv
// Pipelined instruction sequencer with clock-exact timing, accumulator unit and debug hold.
// How it works
// - Opcodes and flag effects match classic set.
// - Durations counted in plain clocks only.
// - Most instructions: clocks equal byte count.
// - Untaken conditional branch one clock shorter.
// - At most eight clocks; divide eight, multiply four.
// - Up to one instruction per clock.
// - All 256 opcode bytes with their tabled clock counts.
// - Add forms: register 1, direct/immediate/indirect 2.
// - Add-with-carry register form: one byte, one clock.
// - Immediate logic to direct three; acc store two.
// - Indirect logic into accumulator takes two clocks.
// - Debug halt, resume, step, breakpoints, register access.
// - Debug uses no user memory or resources.
// - Pointer external moves: one byte, three clocks.
// - Compare indirect jump: four untaken, five taken.
`include "pcit_map.svh"
`default_nettype none
module pcit_core #(
    parameter int NBKPT = 4
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] code_data_in,
    output logic [15:0] code_addr_out,
    input wire logic [7:0] opnd_in,
    input wire logic cond_in,
    input wire logic redir_in,
    input wire logic [15:0] target_in,
    input wire pcit_pkg::pcit_dbg_req_t dbg_in,
    input wire pcit_pkg::pcit_bkpt_t [NBKPT-1:0] bkpt_in,
    output pcit_pkg::pcit_retire_t retire_out,
    output logic halted_out,
    output logic [7:0] acc_out,
    output logic [7:0] psw_out,
    output logic [15:0] dbg_rdata_out
);
    import pcit_pkg::*;

    pcit_state_t state_ff;
    pcit_state_t nxt_state;
    logic [15:0] pc_ff;
    logic [15:0] nxt_pc;
    logic [3:0] k_ff;
    logic [3:0] nxt_k;
    logic ext_ff;
    logic nxt_ext;
    logic [7:0] op_ff;
    pcit_tim_t tim_ff;
    logic [7:0] acc_ff;
    logic [7:0] nxt_acc;
    logic [7:0] psw_ff;
    logic [7:0] nxt_psw;
    logic step_ff;
    logic nxt_step;
    logic skip_ff;
    logic nxt_skip;
    pcit_retire_t ret_ff;
    logic [15:0] rd_ff;

    logic first;
    pcit_tim_t rom_tim;
    pcit_tim_t cur_tim;
    logic [7:0] cur_op;
    logic bp_hit;
    logic stop_now;
    logic active;
    logic cond_now;
    logic take;
    logic base_end;
    logic last;
    logic fetch;
    logic [7:0] alu_b;
    pcit_alu_t alu;
    logic dbg_wr;

    // True when any enabled breakpoint sits on the given address.
    function automatic logic bp_match(input logic [15:0] pc, input pcit_bkpt_t [NBKPT-1:0] bp);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NBKPT; i++) begin
            hit = hit | (bp[i].en && (bp[i].addr == pc));
        end
        return hit;
    endfunction

    // Accumulator operations; only add and subtract forms touch carry, aux and overflow.
    function automatic pcit_alu_t alu_of(input logic [7:0] op, input logic [7:0] a,
                                         input logic [7:0] b, input logic cy);
        pcit_alu_t r;
        logic [8:0] s;
        logic [4:0] h;
        logic ci;
        r = '0;
        s = '0;
        h = '0;
        ci = (op[7:4] == 4'h3) ? cy : 1'b0;
        r.we = 1'b1;
        if (op == `PCIT_OP_INCA) begin
            r.res = a + 8'h01;
        end else if (op == `PCIT_OP_DECA) begin
            r.res = a - 8'h01;
        end else if (op == `PCIT_OP_CLRA) begin
            r.res = 8'h00;
        end else if (op == `PCIT_OP_CPLA) begin
            r.res = ~a;
        end else if (op == `PCIT_OP_SWAPA) begin
            r.res = {a[3:0], a[7:4]};
        end else if (op == `PCIT_OP_MOVAI || (op[7:4] == 4'he && op[3:0] > 4'h4)) begin
            r.res = b;
        end else if (op[3:0] < 4'h4) begin
            r.we = 1'b0;
        end else begin
            unique case (op[7:4])
                4'h2, 4'h3: begin
                    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
                    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
                    r.fl = 1'b1;
                    r.ov = (a[7] == b[7]) && (s[7] != a[7]);
                end
                4'h9: begin
                    s = {1'b0, a} - {1'b0, b} - {8'h00, cy};
                    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cy};
                    r.fl = 1'b1;
                    r.ov = (a[7] != b[7]) && (s[7] != a[7]);
                end
                4'h4: s = {1'b0, a | b};
                4'h5: s = {1'b0, a & b};
                4'h6: s = {1'b0, a ^ b};
                default: r.we = 1'b0;
            endcase
            r.res = s[7:0];
            r.cy = s[8];
            r.ac = h[4];
        end
        return r;
    endfunction

    // Timing table lookup on the byte fetched in the opcode clock.
    pcit_tim_rom u_rom (
        .op_in(code_data_in),
        .tim_out(rom_tim)
    );

    // Opcode clock and the decode that stays valid for the rest of the instruction.
    assign first = (state_ff == ST_RUN) && (k_ff == 4'h0);
    assign cur_op = first ? code_data_in : op_ff;
    assign cur_tim = first ? rom_tim : tim_ff;

    // Halt and breakpoints act only at an instruction boundary; resume steps past them.
    assign bp_hit = bp_match(pc_ff, bkpt_in);
    assign stop_now = first && !skip_ff && (bp_hit || dbg_in.halt);
    assign active = (state_ff == ST_RUN) && !stop_now;

    // Conditions the core owns are taken from its own carry flag and accumulator; the rest come in.
    assign cond_now = (cur_op == `PCIT_OP_JC) ? psw_ff[`PCIT_PSW_CY] :
                      (cur_op == `PCIT_OP_JNC) ? !psw_ff[`PCIT_PSW_CY] :
                      (cur_op == `PCIT_OP_JZ) ? (acc_ff == 8'h00) :
                      (cur_op == `PCIT_OP_JNZ) ? (acc_ff != 8'h00) : cond_in;
    assign take = cur_tim.cond && cond_now;

    // The table count ends an instruction; a taken branch runs one clock more.
    assign base_end = (k_ff == (cur_tim.cyc - 4'h1));
    assign last = active && (ext_ff || (base_end && !take));
    assign nxt_ext = active && !ext_ff && base_end && take;

    // One program byte per clock while bytes remain; later clocks stall fetch.
    assign fetch = active && (k_ff < {2'b00, cur_tim.bytes});
    assign nxt_k = last ? 4'h0 : (active ? k_ff + 4'h1 : k_ff);

    // Immediate operands arrive with the last byte; others from the operand port.
    assign alu_b = (cur_op[3:0] == 4'h4) ? code_data_in : opnd_in;
    assign alu = alu_of(cur_op, acc_ff, alu_b, psw_ff[`PCIT_PSW_CY]);
    assign dbg_wr = (state_ff == ST_HALT) && dbg_in.wr;

    // Debug register writes land only while halted, so running code is never disturbed.
    assign nxt_pc = (dbg_wr && dbg_in.sel == SEL_PC) ? dbg_in.wdata :
                    (last && redir_in) ? target_in :
                    fetch ? pc_ff + 16'h0001 : pc_ff;
    assign nxt_acc = (dbg_wr && dbg_in.sel == SEL_ACC) ? dbg_in.wdata[7:0] :
                     (last && alu.we) ? alu.res : acc_ff;

    // Flags follow the classic rules; parity always tracks the accumulator.
    always_comb begin
        nxt_psw = psw_ff;
        if (dbg_wr && dbg_in.sel == SEL_PSW) begin
            nxt_psw = dbg_in.wdata[7:0];
        end else if (last && alu.fl) begin
            nxt_psw[`PCIT_PSW_CY] = alu.cy;
            nxt_psw[`PCIT_PSW_AC] = alu.ac;
            nxt_psw[`PCIT_PSW_OV] = alu.ov;
        end
        nxt_psw[`PCIT_PSW_P] = ^nxt_acc;
    end

    // Run and halt control; debug state lives here and takes no user memory.
    always_comb begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        nxt_skip = skip_ff;
        unique case (state_ff)
            ST_RUN: begin
                if (stop_now || (last && step_ff)) begin
                    nxt_state = ST_HALT;
                    nxt_step = 1'b0;
                end
                if (first && active) begin
                    nxt_skip = 1'b0;
                end
            end
            ST_HALT: begin
                if (dbg_in.step || dbg_in.run) begin
                    nxt_state = ST_RUN;
                    nxt_step = dbg_in.step;
                    nxt_skip = 1'b1;
                end
            end
        endcase
    end

    // Sequencer state.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff <= ST_RUN;
            k_ff <= 4'h0;
            ext_ff <= 1'b0;
            step_ff <= 1'b0;
            skip_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            k_ff <= nxt_k;
            ext_ff <= nxt_ext;
            step_ff <= nxt_step;
            skip_ff <= nxt_skip;
        end
    end

    // Architectural state.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pc_ff <= `PCIT_PC_RST;
            acc_ff <= `PCIT_ACC_RST;
            psw_ff <= `PCIT_PSW_RST;
        end else begin
            pc_ff <= nxt_pc;
            acc_ff <= nxt_acc;
            psw_ff <= nxt_psw;
        end
    end

    // Opcode and timing are kept from the opcode clock for the rest of the instruction.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            op_ff <= 8'h00;
            tim_ff <= '0;
        end else if (first && active) begin
            op_ff <= code_data_in;
            tim_ff <= rom_tim;
        end
    end

    // Retirement report and debug readback; one retire per clock at best.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ret_ff <= '0;
            rd_ff <= 16'h0000;
        end else begin
            ret_ff <= '{valid: last, op: cur_op, cyc: k_ff + 4'h1, taken: ext_ff};
            rd_ff <= (dbg_in.sel == SEL_PC) ? pc_ff :
                     (dbg_in.sel == SEL_ACC) ? {8'h00, acc_ff} : {8'h00, psw_ff};
        end
    end

    assign code_addr_out = pc_ff;
    assign retire_out = ret_ff;
    assign halted_out = (state_ff == ST_HALT);
    assign acc_out = acc_ff;
    assign psw_out = psw_ff;
    assign dbg_rdata_out = rd_ff;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    a_fetch_one_byte: assert property (
        fetch && !(last && redir_in) |=> code_addr_out == $past(code_addr_out) + 16'h0001)
        else $error("fetch did not advance by one byte");

    a_max_eight_cycles: assert property (
        retire_out.valid |-> retire_out.cyc != 4'h0 && retire_out.cyc <= `PCIT_MAX_CYC)
        else $error("instruction exceeded eight clocks");

    a_div_eight_cycles: assert property (
        retire_out.valid && retire_out.op == `PCIT_OP_DIV |-> retire_out.cyc == `PCIT_DIV_CYC)
        else $error("divide did not take eight clocks");

    a_mul_stall_four: assert property (
        first && active && code_data_in == `PCIT_OP_MUL |=> !fetch [*3] ##1 retire_out.valid)
        else $error("multiply did not stall three clocks and retire");

    a_addc_reg_sum: assert property (
        last && cur_op[7:3] == 5'b00111 |=> retire_out.cyc == 4'h1 &&
        acc_out == 8'($past(acc_ff) + $past(opnd_in) + {7'h00, $past(psw_ff[7])}))
        else $error("register add with carry wrong");

    a_arith_indirect: assert property (
        retire_out.valid && retire_out.op[7:4] inside {4'h2, 4'h3, 4'h9} &&
        retire_out.op[3:1] == 3'b011 |-> retire_out.cyc == 4'h2)
        else $error("indirect arithmetic not two clocks");

    a_logic_indirect: assert property (
        retire_out.valid && retire_out.op[7:4] inside {4'h4, 4'h5, 4'h6} &&
        retire_out.op[3:1] == 3'b011 |-> retire_out.cyc == 4'h2)
        else $error("indirect logic not two clocks");

    a_logic_direct_imm: assert property (
        retire_out.valid && retire_out.op[7:4] inside {4'h4, 4'h5, 4'h6} |->
        (retire_out.op[3:0] != 4'h3 || retire_out.cyc == 4'h3) &&
        (retire_out.op[3:0] != 4'h2 || retire_out.cyc == 4'h2))
        else $error("direct logic timing wrong");

    a_movx_dptr: assert property (
        retire_out.valid && retire_out.op inside {8'he0, 8'hf0} |-> retire_out.cyc == 4'h3)
        else $error("pointer external move not three clocks");

    a_cjne_indirect: assert property (
        retire_out.valid && retire_out.op[7:1] == 7'b1011011 |->
        retire_out.cyc == (retire_out.taken ? 4'h5 : 4'h4))
        else $error("indirect compare jump timing wrong");

    a_branch_extra: assert property (
        retire_out.valid && retire_out.op[7:6] == 2'b01 && retire_out.op[3:0] == 4'h0 |->
        retire_out.cyc == (retire_out.taken ? 4'h3 : 4'h2))
        else $error("short conditional branch timing wrong");

    a_halt_freezes: assert property (
        halted_out && !dbg_in.wr |=> $stable(code_addr_out) && $stable(acc_out))
        else $error("state changed while halted");
endmodule
`default_nettype wire

// ===== logic/pcit_map.svh
// Constants for the pipelined instruction timing core: codes, bit positions, resets.
`ifndef PCIT_MAP_SVH
`define PCIT_MAP_SVH

// Timing entry codes {conditional, bytes[1:0], clocks[3:0]}; a taken branch adds one clock.
`define PCIT_E11 7'h11
`define PCIT_E12 7'h12
`define PCIT_E13 7'h13
`define PCIT_E14 7'h14
`define PCIT_E15 7'h15
`define PCIT_E18 7'h18
`define PCIT_E22 7'h22
`define PCIT_E23 7'h23
`define PCIT_E33 7'h33
`define PCIT_E34 7'h34
`define PCIT_C22 7'h62
`define PCIT_C33 7'h73
`define PCIT_C34 7'h74

// Opcodes that the core treats specially.
`define PCIT_OP_INCA 8'h04
`define PCIT_OP_DECA 8'h14
`define PCIT_OP_JC 8'h40
`define PCIT_OP_JNC 8'h50
`define PCIT_OP_JZ 8'h60
`define PCIT_OP_JNZ 8'h70
`define PCIT_OP_MOVAI 8'h74
`define PCIT_OP_DIV 8'h84
`define PCIT_OP_MUL 8'ha4
`define PCIT_OP_SWAPA 8'hc4
`define PCIT_OP_CLRA 8'he4
`define PCIT_OP_CPLA 8'hf4

// Program status word bit positions.
`define PCIT_PSW_CY 7
`define PCIT_PSW_AC 6
`define PCIT_PSW_OV 2
`define PCIT_PSW_P 0

// Reset values and cycle limits.
`define PCIT_PC_RST 16'h0000
`define PCIT_ACC_RST 8'h00
`define PCIT_PSW_RST 8'h00
`define PCIT_MAX_CYC 4'h8
`define PCIT_DIV_CYC 4'h8
`define PCIT_MUL_CYC 4'h4

`endif

// ===== logic/pcit_pkg.sv
// Types shared by the instruction timing core and its timing table.
`default_nettype none
package pcit_pkg;
    // One timing table entry; layout matches the entry codes of the map header.
    typedef struct packed {
        logic cond;
        logic [1:0] bytes;
        logic [3:0] cyc;
    } pcit_tim_t;

    // One hardware breakpoint as handed over by the debug port.
    typedef struct packed {
        logic en;
        logic [15:0] addr;
    } pcit_bkpt_t;

    // Debug port request levels and register write.
    typedef struct packed {
        logic halt;
        logic run;
        logic step;
        logic wr;
        logic [1:0] sel;
        logic [15:0] wdata;
    } pcit_dbg_req_t;

    // Retirement report of one instruction.
    typedef struct packed {
        logic valid;
        logic [7:0] op;
        logic [3:0] cyc;
        logic taken;
    } pcit_retire_t;

    // Accumulator result with flag effects.
    typedef struct packed {
        logic we;
        logic fl;
        logic [7:0] res;
        logic cy;
        logic ac;
        logic ov;
    } pcit_alu_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_HALT = 2'b10
    } pcit_state_t;

    typedef enum logic [1:0] {
        SEL_PC = 2'b00,
        SEL_ACC = 2'b01,
        SEL_PSW = 2'b10
    } pcit_dsel_t;
endpackage
`default_nettype wire

// ===== logic/pcit_tim_rom.sv
// Opcode to length and clock count table of the instruction timing core.
`include "pcit_map.svh"
`default_nettype none
module pcit_tim_rom (
    input wire logic [7:0] op_in,
    output pcit_pkg::pcit_tim_t tim_out
);
    import pcit_pkg::*;

    // Column by column over the low nibble; every byte value has an entry.
    function automatic pcit_tim_t tim_of(input logic [7:0] op);
        logic [3:0] hi;
        logic [6:0] e;
        hi = op[7:4];
        e = `PCIT_E11;
        if (op[3]) begin
            case (hi)
                4'h7, 4'h8, 4'ha: e = `PCIT_E22;
                4'hb: e = `PCIT_C33;
                4'hd: e = `PCIT_C22;
                default: e = `PCIT_E11;
            endcase
        end else begin
            case (op[2:0])
                3'h6, 3'h7: begin
                    case (hi)
                        4'h7, 4'h8, 4'ha: e = `PCIT_E22;
                        4'hb: e = `PCIT_C34;
                        default: e = `PCIT_E12;
                    endcase
                end
                3'h5: begin
                    case (hi)
                        4'h7, 4'h8: e = `PCIT_E33;
                        4'ha: e = `PCIT_E11;
                        4'hb, 4'hd: e = `PCIT_C33;
                        default: e = `PCIT_E22;
                    endcase
                end
                3'h4: begin
                    case (hi)
                        4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf: e = `PCIT_E11;
                        4'h8: e = `PCIT_E18;
                        4'ha: e = `PCIT_E14;
                        4'hb: e = `PCIT_C33;
                        default: e = `PCIT_E22;
                    endcase
                end
                3'h3: begin
                    case (hi)
                        4'h4, 4'h5, 4'h6: e = `PCIT_E33;
                        4'h7, 4'h8, 4'h9, 4'he, 4'hf: e = `PCIT_E13;
                        default: e = `PCIT_E11;
                    endcase
                end
                3'h2: begin
                    case (hi)
                        4'h0, 4'h1: e = `PCIT_E34;
                        4'h2, 4'h3: e = `PCIT_E15;
                        4'he, 4'hf: e = `PCIT_E13;
                        default: e = `PCIT_E22;
                    endcase
                end
                3'h1: e = `PCIT_E23;
                default: begin
                    case (hi)
                        4'h0: e = `PCIT_E11;
                        4'h1, 4'h2, 4'h3: e = `PCIT_C33;
                        4'h4, 4'h5, 4'h6, 4'h7: e = `PCIT_C22;
                        4'h8: e = `PCIT_E23;
                        4'h9: e = `PCIT_E33;
                        4'he, 4'hf: e = `PCIT_E13;
                        default: e = `PCIT_E22;
                    endcase
                end
            endcase
        end
        return pcit_tim_t'(e);
    endfunction

    // Pure lookup; the core registers what it keeps.
    assign tim_out = tim_of(op_in);
endmodule
`default_nettype wire

// ===== tb/pcit_prog_mem.sv
// Program memory model: a combinational code store that answers in the same clock.
`default_nettype none
module pcit_prog_mem (
    input wire logic [15:0] addr_in,
    output logic [7:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    // Only the low page is populated; above it the bus shows a pattern that changes each fetch.
    assign data_out = (addr_in[15:8] == 8'h00) ? mem[addr_in[7:0]] : ~addr_in[7:0];
endmodule
`default_nettype wire

// ===== tb/tb_pipelined_cpu_instruction_timing.sv
// Bench of the timing core: random programs checked against an integer model.
`default_nettype none
module tb_pipelined_cpu_instruction_timing;
    timeunit 1ns;
    timeprecision 1ps;
    import pcit_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [15:0] caddr;
    logic [7:0] cdata;
    logic [7:0] opnd = 8'h00;
    logic cond = 1'b0;
    logic redir = 1'b0;
    logic [15:0] tgt = 16'h0000;
    pcit_dbg_req_t dbg = '0;
    pcit_bkpt_t [3:0] bkpt = '0;
    pcit_retire_t ret;
    logic halted;
    logic [7:0] acc;
    logic [7:0] psw;
    logic [15:0] rdata;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    bit [31:0] seed = 32'hcbfd0bb4;
    int q_op[$];
    int q_imm[$];
    int q_cnd[$];
    int q_tgt[$];
    int m_acc = 0;
    int m_cy = 0;
    int m_ac = 0;
    int m_ov = 0;

    pcit_core #(.NBKPT(4)) dut (.clk_in(clk_in), .rstn_in(rstn_in), .code_data_in(cdata),
        .code_addr_out(caddr), .opnd_in(opnd), .cond_in(cond), .redir_in(redir),
        .target_in(tgt), .dbg_in(dbg), .bkpt_in(bkpt), .retire_out(ret),
        .halted_out(halted), .acc_out(acc), .psw_out(psw), .dbg_rdata_out(rdata));
    pcit_prog_mem pm (.addr_in(caddr), .data_out(cdata));

    // Free-running system clock; a hang is cut short by the cycle ceiling.
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            finish_test();
        end
    end

    function automatic bit [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Length and clocks of an opcode as {bytes, clocks}; a taken branch adds one clock.
    function automatic int tim(int op);
        int lo;
        lo = op & 15;
        case (op)
            'ha4: return 'h14;
            'h84: return 'h18;
            'he0, 'hf0: return 'h13;
            'h53, 'h43, 'h63: return 'h33;
            'hb6: return 'h34;
            'h40, 'h50, 'h60, 'h70, 'hf5, 'h74: return 'h22;
            'h04, 'h14, 'he4, 'hf4, 'hc4, 'h00: return 'h11;
            default: return (lo < 6) ? 'h22 : (lo < 8) ? 'h12 : 'h11;
        endcase
    endfunction

    task automatic chk_ret(input logic [12:0] got, input logic [12:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected retire at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Random mix of accumulator forms and timing specials; a taken compare jumps two bytes.
    task automatic build();
        int pc, op, c;
        bit [31:0] r;
        int hi[6] = '{2, 3, 9, 5, 4, 6};
        int sp[19] = '{'ha4, 'h84, 'he0, 'hf0, 'h53, 'h43, 'h63, 'hb6, 'h40, 'h50, 'h60,
            'h70, 'hf5, 'h74, 'h04, 'h14, 'he4, 'hf4, 'hc4};
        pc = 0;
        for (int i = 0; i < 40; i++) begin
            r = xs();
            op = r[0] ? hi[r[7:4] % 6] * 16 + 4 + r[11:8] % 12 : sp[r[15:8] % 19];
            c = r[16];
            pm.mem[pc] = op[7:0];
            pm.mem[pc + 1] = r[31:24];
            pm.mem[pc + 2] = r[23:16];
            pc += tim(op) >> 4;
            if (op == 'hb6 && c == 1) begin
                pm.mem[pc] = 8'h84;
                pm.mem[pc + 1] = 8'h84;
                pc += 2;
            end
            q_op.push_back(op);
            q_imm.push_back(r[31:24]);
            q_cnd.push_back(c);
            q_tgt.push_back(pc);
        end
        pm.mem[pc] = 8'h00;
        pm.mem[pc + 1] = 8'h00;
    endtask

    // Inputs for the coming instruction change at the falling edge after the last retire.
    task automatic drive_next();
        bit [31:0] r;
        r = xs();
        opnd = r[7:0];
        cond = q_op.size() > 0 ? q_cnd[0] : 0;
        redir = q_op.size() > 0 && q_op[0] == 'hb6 && q_cnd[0] == 1;
        tgt = q_op.size() > 0 ? q_tgt[0] : 0;
    endtask

    task automatic check_retire();
        int op, im, tk, a, o, c, s, p;
        op = 0;
        im = 0;
        c = 0;
        if (q_op.size() > 0) begin
            op = q_op.pop_front();
            im = q_imm.pop_front();
            c = q_cnd.pop_front();
            void'(q_tgt.pop_front());
        end
        a = m_acc;
        o = ((op & 15) == 4) ? im : opnd;
        tk = op == 'hb6 ? c : op == 'h40 ? m_cy : op == 'h50 ? !m_cy :
            op == 'h60 ? a == 0 : op == 'h70 ? a != 0 : 0;
        c = m_cy;
        case (op)
            'h04: m_acc = (a + 1) & 255;
            'h14: m_acc = (a - 1) & 255;
            'he4: m_acc = 0;
            'hf4: m_acc = a ^ 255;
            'hc4: m_acc = ((a << 4) | (a >> 4)) & 255;
            'h74: m_acc = im;
            default: ;
        endcase
        if ((op & 15) >= 4) begin
            case (op >> 4)
                2, 3: begin
                    c = (op >> 4) == 3 ? c : 0;
                    s = a + o + c;
                    m_ac = ((a & 15) + (o & 15) + c) >> 4;
                    m_ov = ((a ^ s) & (o ^ s) & 128) != 0;
                    m_cy = s >> 8;
                    m_acc = s & 255;
                end
                9: begin
                    s = a - o - c;
                    m_ac = (a & 15) < (o & 15) + c;
                    m_ov = ((a ^ o) & (a ^ s) & 128) != 0;
                    m_cy = a < o + c;
                    m_acc = s & 255;
                end
                5: m_acc = a & o;
                4: m_acc = a | o;
                6: m_acc = a ^ o;
                default: ;
            endcase
        end
        p = $countones(m_acc) & 1;
        chk_ret({ret.op, ret.cyc, ret.taken}, {op[7:0], 4'((tim(op) & 15) + tk), tk[0]});
        chk_val(16'(acc), 16'(m_acc));
        chk_val(16'(psw), 16'(m_cy * 128 + m_ac * 64 + m_ov * 4 + p));
        drive_next();
    endtask

    always @(negedge clk_in) begin
        if (rstn_in && ret.valid === 1'b1) begin
            check_retire();
        end
    end

    task automatic finish_test();
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Program run, then halt, register access, breakpoint and single step.
    initial begin
        for (int i = 0; i < 256; i++) begin
            pm.mem[i] = 8'h00;
        end
        build();
        drive_next();
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        rstn_in = 1'b1;
        for (int i = 0; i < 2000 && q_op.size() > 0; i++) begin
            @(negedge clk_in);
        end
        chk_val(16'(q_op.size()), 16'h0000);
        dbg.halt = 1'b1;
        repeat (3) @(negedge clk_in);
        chk_val(16'(halted), 16'h0001);
        dbg.wr = 1'b1;
        dbg.wdata = 16'h00f0;
        @(negedge clk_in);
        dbg.wr = 1'b0;
        dbg.sel = SEL_ACC;
        repeat (2) @(negedge clk_in);
        chk_val(rdata, 16'(m_acc));
        chk_val(caddr, 16'h00f0);
        // Accumulator then status writes while halted; parity follows the new accumulator.
        dbg.wr = 1'b1;
        dbg.wdata = 16'h005a;
        @(negedge clk_in);
        dbg.sel = SEL_PSW;
        dbg.wdata = 16'h0080;
        @(negedge clk_in);
        dbg.wr = 1'b0;
        m_acc = 'h5a;
        m_cy = 1;
        m_ac = 0;
        m_ov = 0;
        @(negedge clk_in);
        chk_val({acc, psw}, 16'h5a80);
        chk_val(rdata, 16'h0080);
        bkpt[0] = '{en: 1'b1, addr: 16'h00f3};
        dbg.halt = 1'b0;
        dbg.run = 1'b1;
        @(negedge clk_in);
        dbg.run = 1'b0;
        repeat (6) @(negedge clk_in);
        chk_val({halted, caddr[14:0]}, 16'h80f3);
        dbg.step = 1'b1;
        @(negedge clk_in);
        dbg.step = 1'b0;
        repeat (4) @(negedge clk_in);
        chk_val({halted, caddr[14:0]}, 16'h80f4);
        dbg.sel = SEL_PC;
        repeat (2) @(negedge clk_in);
        chk_val(rdata, 16'h00f4);
        finish_test();
    end
endmodule
`default_nettype wire
